// >>> design/ftd_delay_line.sv
/*
 * Fixed-length register delay line with registered output.
 * Assumes same clock as its source; synchronous active-high reset clears it.
 */
`timescale 1ns/1ps
module ftd_delay_line #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 1
) (
    input  wire logic             clock,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage_q [DEPTH];

    // refuse shapes the shift chain cannot build
    if (DEPTH < 1 || WIDTH < 1) begin : g_bad_shape
        $error("delay line needs positive width and depth");
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            for (int i = 0; i < DEPTH; i++) begin
                stage_q[i] <= '0;
            end
        end else begin
            stage_q[0] <= din;
            for (int i = 1; i < DEPTH; i++) begin
                stage_q[i] <= stage_q[i-1];
            end
        end
    end

    assign dout = stage_q[DEPTH-1];
endmodule

// >>> design/ftd_fast_detect.sv
/*
 * Fast magnitude threshold detector with dwell hysteresis, delayed overrange
 * indicator and a three-wire serial register port.
 * Assumes samples arrive every clock from logic on the same clock; the serial
 * pins are asynchronous and much slower than the sample clock.
 */
`timescale 1ns/1ps
module ftd_fast_detect (
    input  wire logic                 clock,
    input  wire logic                 srst,
    input  wire ftd_pkg::ftd_sample_t sample,
    input  wire logic                 spi_cs_n,
    input  wire logic                 spi_sclk,
    input  wire logic                 spi_sdio_in,
    output logic                      spi_sdio_out,
    output logic                      spi_sdio_oe,
    output logic                      threshold_flag,
    output logic                      overrange_out
);
    // ---------------- register storage ----------------
    logic [7:0]                   ctrl_q;
    logic [7:0]                   upper_lo_q;
    logic [4:0]                   upper_hi_q;
    logic [7:0]                   lower_lo_q;
    logic [4:0]                   lower_hi_q;
    logic [7:0]                   dwell_lo_q;
    logic [7:0]                   dwell_hi_q;
    ftd_pkg::ftd_cfg_t            cfg;

    // ---------------- serial port ----------------
    logic [2:0]                   pin_s1_q;
    logic [2:0]                   pin_s2_q;
    logic                         sclk_prev_q;
    logic                         cs_n_s;
    logic                         sclk_s;
    logic                         sdi_s;
    logic                         sclk_rise;
    logic                         sclk_fall;
    ftd_pkg::ftd_spi_state_t      state_q;
    logic [3:0]                   icnt_q;
    logic [2:0]                   bcnt_q;
    logic [14:0]                  ish_q;
    logic [6:0]                   rx_q;
    logic [7:0]                   tx_q;
    logic                         rd_q;
    logic [ftd_pkg::ADDR_W-1:0]   addr_q;
    logic                         wr_fire;
    logic [7:0]                   wr_byte;
    logic [7:0]                   rd_first;

    // ---------------- detector ----------------
    logic [ftd_pkg::MAG_W-1:0]    mag_in;
    logic [ftd_pkg::MAG_W-1:0]    mag_dly;
    logic [ftd_pkg::DWELL_W-1:0]  dwell_eff;
    logic [ftd_pkg::DWELL_W-1:0]  dwell_cnt_q;
    logic                         flag_q;
    logic                         above_upper;
    logic                         below_lower;

    function automatic logic [ftd_pkg::MAG_W-1:0] mag_of(
        input logic [ftd_pkg::SAMPLE_W-1:0] s
    );
        mag_of = s[ftd_pkg::SAMPLE_W-1] ? ftd_pkg::MAG_W'(~s + 14'h0001) : s;
    endfunction

    function automatic logic [7:0] rd_byte(input logic [ftd_pkg::ADDR_W-1:0] a);
        case (a)
            ftd_pkg::ADDR_CTRL:     rd_byte = {5'h00, overrange_out, flag_q,
                                               ctrl_q[ftd_pkg::CTRL_ENABLE_BIT]};
            ftd_pkg::ADDR_UPPER_LO: rd_byte = upper_lo_q;
            ftd_pkg::ADDR_UPPER_HI: rd_byte = {3'h0, upper_hi_q};
            ftd_pkg::ADDR_LOWER_LO: rd_byte = lower_lo_q;
            ftd_pkg::ADDR_LOWER_HI: rd_byte = {3'h0, lower_hi_q};
            ftd_pkg::ADDR_DWELL_LO: rd_byte = dwell_lo_q;
            ftd_pkg::ADDR_DWELL_HI: rd_byte = dwell_hi_q;
            default:                rd_byte = 8'h00;
        endcase
    endfunction

    // pin synchronisers: first stage feeds only the second
    always_ff @(posedge clock) begin
        if (srst) begin
            pin_s1_q    <= 3'h5;
            pin_s2_q    <= 3'h5;
            sclk_prev_q <= 1'b0;
        end else begin
            pin_s1_q    <= {spi_cs_n, spi_sclk, spi_sdio_in};
            pin_s2_q    <= pin_s1_q;
            sclk_prev_q <= pin_s2_q[1];
        end
    end

    assign cs_n_s    = pin_s2_q[2];
    assign sclk_s    = pin_s2_q[1];
    assign sdi_s     = pin_s2_q[0];
    assign sclk_rise = sclk_s && !sclk_prev_q;
    assign sclk_fall = !sclk_s && sclk_prev_q;

    assign wr_fire = (state_q == ftd_pkg::FTD_DATA) && !rd_q && sclk_rise
                     && (bcnt_q == ftd_pkg::BYTE_LAST);
    assign wr_byte = {rx_q, sdi_s};

    always_comb rd_first = rd_byte({ish_q[11:0], sdi_s});

    // frame sequencing: instruction then streamed bytes, address descending
    always_ff @(posedge clock) begin
        if (srst || cs_n_s) begin
            state_q <= ftd_pkg::FTD_IDLE;
            icnt_q  <= 4'h0;
            bcnt_q  <= 3'h0;
            ish_q   <= 15'h0000;
            rx_q    <= 7'h00;
            rd_q    <= 1'b0;
            addr_q  <= '0;
        end else begin
            case (state_q)
                ftd_pkg::FTD_IDLE: begin
                    state_q <= ftd_pkg::FTD_INSTR;
                    icnt_q  <= 4'h0;
                end
                ftd_pkg::FTD_INSTR: begin
                    if (sclk_rise) begin
                        ish_q  <= {ish_q[13:0], sdi_s};
                        icnt_q <= icnt_q + 4'h1;
                        if (icnt_q == ftd_pkg::INSTR_LAST) begin
                            rd_q    <= ish_q[ftd_pkg::INSTR_RW - 1];
                            addr_q  <= {ish_q[11:0], sdi_s};
                            bcnt_q  <= 3'h0;
                            state_q <= ftd_pkg::FTD_DATA;
                        end
                    end
                end
                ftd_pkg::FTD_DATA: begin
                    if (sclk_rise) begin
                        rx_q   <= {rx_q[5:0], sdi_s};
                        bcnt_q <= bcnt_q + 3'h1;
                        if (bcnt_q == ftd_pkg::BYTE_LAST) begin
                            addr_q <= addr_q - 13'h0001;
                        end
                    end
                end
                default: begin
                    state_q <= ftd_pkg::FTD_IDLE;
                end
            endcase
        end
    end

    // readback shifter: bit changes on falling edge, first bit ready at once
    always_ff @(posedge clock) begin
        if (srst || cs_n_s) begin
            tx_q         <= 8'h00;
            spi_sdio_out <= 1'b0;
            spi_sdio_oe  <= 1'b0;
        end else if (state_q == ftd_pkg::FTD_INSTR && sclk_rise
                     && icnt_q == ftd_pkg::INSTR_LAST
                     && ish_q[ftd_pkg::INSTR_RW - 1]) begin
            tx_q         <= rd_first;
            spi_sdio_out <= rd_first[7];
            spi_sdio_oe  <= 1'b1;
        end else if (state_q == ftd_pkg::FTD_DATA && rd_q) begin
            if (sclk_rise && bcnt_q == ftd_pkg::BYTE_LAST) begin
                tx_q <= rd_byte(addr_q - 13'h0001);
            end else if (sclk_fall) begin
                spi_sdio_out <= tx_q[ftd_pkg::BYTE_LAST - bcnt_q];
            end
        end
    end

    // register writes
    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl_q     <= ftd_pkg::RST_CTRL;
            upper_lo_q <= ftd_pkg::RST_THR_LO;
            upper_hi_q <= ftd_pkg::RST_THR_HI;
            lower_lo_q <= ftd_pkg::RST_THR_LO;
            lower_hi_q <= ftd_pkg::RST_THR_HI;
            dwell_lo_q <= ftd_pkg::RST_DWELL;
            dwell_hi_q <= ftd_pkg::RST_DWELL;
        end else if (wr_fire) begin
            case (addr_q)
                ftd_pkg::ADDR_CTRL:     ctrl_q     <= {7'h00, wr_byte[0]};
                ftd_pkg::ADDR_UPPER_LO: upper_lo_q <= wr_byte;
                ftd_pkg::ADDR_UPPER_HI: upper_hi_q <= wr_byte[4:0];
                ftd_pkg::ADDR_LOWER_LO: lower_lo_q <= wr_byte;
                ftd_pkg::ADDR_LOWER_HI: lower_hi_q <= wr_byte[4:0];
                ftd_pkg::ADDR_DWELL_LO: dwell_lo_q <= wr_byte;
                ftd_pkg::ADDR_DWELL_HI: dwell_hi_q <= wr_byte;
                default: begin
                end
            endcase
        end
    end

    assign cfg.enable = ctrl_q[ftd_pkg::CTRL_ENABLE_BIT];
    assign cfg.upper  = {upper_hi_q, upper_lo_q};
    assign cfg.lower  = {lower_hi_q, lower_lo_q};
    assign cfg.dwell  = {dwell_hi_q, dwell_lo_q};

    // magnitude of the converter output word, sign dropped; 8192 = full scale
    assign mag_in = mag_of(sample.data);

    ftd_delay_line #(
        .WIDTH (ftd_pkg::MAG_W),
        .DEPTH (ftd_pkg::MAG_PIPE)
    ) u_mag_pipe (
        .clock (clock),
        .srst  (srst),
        .din   (mag_in),
        .dout  (mag_dly)
    );

    ftd_delay_line #(
        .WIDTH (1),
        .DEPTH (ftd_pkg::OVR_LAT)
    ) u_ovr_pipe (
        .clock (clock),
        .srst  (srst),
        .din   (sample.overrange),
        .dout  (overrange_out)
    );

    // both comparisons on the delayed full-resolution magnitude
    assign above_upper = mag_dly > {1'b0, cfg.upper};
    assign below_lower = mag_dly < {1'b0, cfg.lower};
    assign dwell_eff   = (cfg.dwell == '0) ? 16'h0001 : cfg.dwell;

    always_ff @(posedge clock) begin
        if (srst || !cfg.enable) begin
            flag_q      <= 1'b0;
            dwell_cnt_q <= '0;
        end else if (above_upper) begin
            flag_q      <= 1'b1;
            dwell_cnt_q <= '0;
        end else if (flag_q) begin
            if (!below_lower) begin
                dwell_cnt_q <= '0;
            end else if (dwell_cnt_q >= dwell_eff - 16'h0001) begin
                flag_q      <= 1'b0;
                dwell_cnt_q <= '0;
            end else begin
                dwell_cnt_q <= dwell_cnt_q + 16'h0001;
            end
        end else begin
            dwell_cnt_q <= '0;
        end
    end

    assign threshold_flag = flag_q;

    // ---------------- assertions ----------------
    default clocking ftd_cb @(posedge clock); endclocking
    default disable iff (srst);

    property p_disabled_low;
        !cfg.enable |=> !threshold_flag;
    endproperty
    a_disabled_low: assert property (p_disabled_low) else $error("flag set while off");

    property p_rise_cause;
        $rose(threshold_flag) |-> $past(above_upper);
    endproperty
    a_rise_cause: assert property (p_rise_cause) else $error("flag rose without cause");

    property p_sign;
        mag_of(sample.data) == mag_of(14'(~sample.data + 14'h0001))
        || sample.data == 14'h2000;
    endproperty
    a_sign: assert property (p_sign) else $error("magnitude depends on sign");

    property p_full_scale;
        sample.data == 14'h2000 |-> mag_in == 14'h2000;
    endproperty
    a_full_scale: assert property (p_full_scale) else $error("full scale not 2^13");

    sequence s_enabled_hot;
        cfg.enable && above_upper;
    endsequence
    property p_upper_set;
        s_enabled_hot ##1 cfg.enable |-> threshold_flag;
    endproperty
    a_upper_set: assert property (p_upper_set) else $error("flag missed upper");

    property p_latency;
        ##6 (mag_dly == $past(mag_in, 6));
    endproperty
    a_latency: assert property (p_latency) else $error("pipeline depth wrong");

    property p_fall_cause;
        $fell(threshold_flag) && $past(cfg.enable) |->
            $past(below_lower) && $past(dwell_cnt_q) == $past(dwell_eff) - 16'h0001;
    endproperty
    a_fall_cause: assert property (p_fall_cause) else $error("flag cleared early");

    property p_dwell_bound;
        threshold_flag |-> dwell_cnt_q < dwell_eff;
    endproperty
    a_dwell_bound: assert property (p_dwell_bound) else $error("dwell count overran");

    property p_restart;
        threshold_flag && cfg.enable && !below_lower ##1 cfg.enable |-> dwell_cnt_q == '0;
    endproperty
    a_restart: assert property (p_restart) else $error("dwell not restarted");

    property p_ovr_delay;
        ##36 (overrange_out == $past(sample.overrange, 36));
    endproperty
    a_ovr_delay: assert property (p_ovr_delay) else $error("overrange delay wrong");
endmodule

// >>> design/ftd_pkg.sv
/*
 * Shared constants, register map and types for the fast threshold detector.
 * Assumes a single sample clock; all users reference items as ftd_pkg::name.
 */
package ftd_pkg;

    localparam int SAMPLE_W  = 14;
    localparam int MAG_W     = 14;
    localparam int THR_W     = 13;
    localparam int DWELL_W   = 16;
    localparam int ADDR_W    = 13;
    localparam int BYTE_W    = 8;

    // register offsets
    localparam logic [12:0] ADDR_CTRL      = 13'h0045;
    localparam logic [12:0] ADDR_UPPER_LO  = 13'h0047;
    localparam logic [12:0] ADDR_UPPER_HI  = 13'h0048;
    localparam logic [12:0] ADDR_LOWER_LO  = 13'h0049;
    localparam logic [12:0] ADDR_LOWER_HI  = 13'h004A;
    localparam logic [12:0] ADDR_DWELL_LO  = 13'h004B;
    localparam logic [12:0] ADDR_DWELL_HI  = 13'h004C;

    // control register fields
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_FLAG_BIT   = 1;
    localparam int CTRL_OVR_BIT    = 2;

    // values after reset
    localparam logic [7:0] RST_CTRL      = 8'h00;
    localparam logic [7:0] RST_THR_LO    = 8'h00;
    localparam logic [4:0] RST_THR_HI    = 5'h00;
    localparam logic [7:0] RST_DWELL     = 8'h00;

    // latencies in sample clock cycles
    localparam int UPPER_LAT = 7;
    localparam int MAG_PIPE  = UPPER_LAT - 1;
    localparam int OVR_LAT   = 36;

    // serial port framing
    localparam int INSTR_BITS  = 16;
    localparam int INSTR_RW    = 15;
    localparam logic [3:0] INSTR_LAST = 4'hF;
    localparam logic [2:0] BYTE_LAST  = 3'h7;

    typedef enum logic [2:0] {
        FTD_IDLE  = 3'b001,
        FTD_INSTR = 3'b010,
        FTD_DATA  = 3'b100
    } ftd_spi_state_t;

    typedef struct packed {
        logic [SAMPLE_W-1:0] data;
        logic                overrange;
    } ftd_sample_t;

    typedef struct packed {
        logic               enable;
        logic [THR_W-1:0]   upper;
        logic [THR_W-1:0]   lower;
        logic [DWELL_W-1:0] dwell;
    } ftd_cfg_t;

endpackage

// >>> dv/fast_threshold_detect_bench.sv
/*
 * Self-checking bench for the fast threshold detector.
 * Assumes the separate serial host model u_host and a reference flag model in this file.
 */
`timescale 1ns/1ps
module fast_threshold_detect_bench;
    typedef struct {
        int   due;
        logic v;
    } ftd_note_t;
    logic                 clock;
    logic                 srst;
    ftd_pkg::ftd_sample_t sample;
    logic                 spi_cs_n, spi_sclk, sdio_line;
    logic                 spi_sdio_out, spi_sdio_oe, threshold_flag, overrange_out;
    int                   fails, num_checks, cyc;
    ftd_note_t            fq[$];
    ftd_note_t            oq[$];
    logic [7:0]           rq[$];
    logic                 m_en   = 1'b0;
    logic                 m_flag = 1'b0;
    logic [12:0]          m_up, m_lo;
    logic [15:0]          m_dw   = 16'h0000;
    int                   m_cnt  = 0;
    logic [12:0]          cfg_up[4] = '{13'h0FFF, 13'h1FFF, 13'h0200, 13'h0010};
    logic [12:0]          cfg_lo[4] = '{13'h0A1D, 13'h1000, 13'h0100, 13'h0008};
    logic [15:0]          cfg_dw[4] = '{16'h0005, 16'h0000, 16'h0103, 16'h0003};
    logic                 cfg_en[4] = '{1'b1, 1'b1, 1'b1, 1'b0};

    ftd_fast_detect dut (
        .clock          (clock),
        .srst           (srst),
        .sample         (sample),
        .spi_cs_n       (spi_cs_n),
        .spi_sclk       (spi_sclk),
        .spi_sdio_in    (sdio_line),
        .spi_sdio_out   (spi_sdio_out),
        .spi_sdio_oe    (spi_sdio_oe),
        .threshold_flag (threshold_flag),
        .overrange_out  (overrange_out)
    );
    ftd_spi_host u_host (
        .clock     (clock),
        .dev_out   (spi_sdio_out),
        .dev_oe    (spi_sdio_oe),
        .spi_cs_n  (spi_cs_n),
        .spi_sclk  (spi_sclk),
        .sdio_line (sdio_line)
    );

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // one sample, reference flag update, notes for both outputs
    task automatic step(input logic [13:0] d, input logic o);
        logic [13:0] mag;
        mag = d[13] ? ~d + 14'h1 : d;
        @(posedge clock);
        sample <= '{data: d, overrange: o};
        if (!m_en) begin
            m_flag = 1'b0;
            m_cnt  = 0;
        end else if (mag > {1'b0, m_up}) begin
            m_flag = 1'b1;
            m_cnt  = 0;
        end else if (m_flag && mag < {1'b0, m_lo}) begin
            m_cnt++;
            if (m_cnt >= ((m_dw == 16'h0000) ? 1 : int'(m_dw))) begin
                m_flag = 1'b0;
                m_cnt  = 0;
            end
        end else begin
            m_cnt = 0;
        end
        fq.push_back('{cyc + 8, m_flag});
        oq.push_back('{cyc + 37, o});
    endtask
    task automatic run_random(input int n);
        logic [13:0] m;
        int          len;
        while (n > 0) begin
            case ($urandom_range(6))
                0: m = 14'h0000;
                1: m = {1'b0, m_lo} - 14'h1;
                2: m = {1'b0, m_lo};
                3: m = {1'b0, m_up};
                4: m = {1'b0, m_up} + 14'h1;
                5: m = 14'h2000;
                default: m = 14'($urandom_range(8191));
            endcase
            len = $urandom_range(12, 1);
            repeat (len) step($urandom_range(1) ? -m : m, 1'($urandom_range(1)));
            n -= len;
        end
    endtask
    task automatic rd_reg(input logic [12:0] a, input int n, input logic [15:0] e);
        if (n == 2) rq.push_back(e[15:8]);
        rq.push_back(e[7:0]);
        u_host.frame(1'b1, a, n, 16'h0000);
    endtask

    always @(negedge clock) begin
        ftd_note_t nt;
        cyc = cyc + 1;
        if (fq.size() > 0 && fq[0].due == cyc) begin
            nt = fq.pop_front();
            chk({7'h0, threshold_flag}, {7'h0, nt.v}, "flag");
        end
        if (oq.size() > 0 && oq[0].due == cyc) begin
            nt = oq.pop_front();
            chk({7'h0, overrange_out}, {7'h0, nt.v}, "overrange");
        end
    end
    always @(u_host.rd_ev) begin
        logic [7:0] e;
        e = (rq.size() > 0) ? rq.pop_front() : ~u_host.rd_byte;
        chk(u_host.rd_byte, e, "register");
    end

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        #2500000;
        fails++;
        final_report();
    end
    initial begin
        srst       = 1'b1;
        sample     = '0;
        fails      = 0;
        num_checks = 0;
        cyc        = 0;
        void'($urandom(32'h2A2D3C33));
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        repeat (4) @(posedge clock);
        rd_reg(ftd_pkg::ADDR_CTRL, 1, 16'h0000);
        rd_reg(ftd_pkg::ADDR_DWELL_HI, 2, 16'h0000);
        for (int c = 0; c < 4; c++) begin
            m_en = cfg_en[c];
            m_up = cfg_up[c];
            m_lo = cfg_lo[c];
            m_dw = cfg_dw[c];
            // reserved and read-only bits written as ones
            u_host.frame(1'b0, ftd_pkg::ADDR_CTRL, 1, {8'h00, 7'h7F, m_en});
            u_host.frame(1'b0, ftd_pkg::ADDR_UPPER_HI, 2, {3'b111, m_up});
            u_host.frame(1'b0, ftd_pkg::ADDR_LOWER_HI, 2, {3'b111, m_lo});
            u_host.frame(1'b0, ftd_pkg::ADDR_DWELL_HI, 2, m_dw);
            u_host.frame(1'b0, 13'h0046, 1, 16'h00A5);
            rd_reg(ftd_pkg::ADDR_CTRL, 1, {15'h0000, m_en});
            rd_reg(ftd_pkg::ADDR_UPPER_HI, 2, {3'b000, m_up});
            rd_reg(ftd_pkg::ADDR_LOWER_HI, 2, {3'b000, m_lo});
            rd_reg(ftd_pkg::ADDR_DWELL_HI, 2, m_dw);
            rd_reg(13'h0046, 1, 16'h0000);
            run_random(400);
            repeat (40) step(14'h1000, 1'b1);
            rd_reg(ftd_pkg::ADDR_CTRL, 1, {13'h0000, 1'b1, m_flag, m_en});
            repeat (int'(m_dw) + 60) step(14'h0000, 1'b0);
        end
        repeat (50) @(posedge clock);
        final_report();
    end
endmodule

// >>> dv/ftd_spi_host.sv
/*
 * Serial register host model that drives the detector's three-wire port.
 * Assumes the device samples the pins on its own sample clock.
 */
`timescale 1ns/1ps
module ftd_spi_host (
    input  wire logic clock,
    input  wire logic dev_out,
    input  wire logic dev_oe,
    output logic      spi_cs_n,
    output logic      spi_sclk,
    output logic      sdio_line
);
    logic       drv_en = 1'b1;
    logic       drv_d  = 1'b0;
    logic       last_q = 1'b0;
    logic [7:0] rd_byte;
    event       rd_ev;
    // released line shows the inverse of its last level
    assign sdio_line = dev_oe ? dev_out : (drv_en ? drv_d : ~last_q);
    always @(posedge clock) last_q <= sdio_line;
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock);
    endtask
    // high phase, low phase with new data, sample just before the rise
    task automatic tick(input logic b, output logic s);
        wait_clk(5);
        spi_sclk <= 1'b0;
        drv_d    <= b;
        wait_clk(5);
        @(negedge clock);
        s = sdio_line;
        @(posedge clock);
        spi_sclk <= 1'b1;
    endtask
    task automatic frame(input logic rd, input logic [12:0] addr, input int n,
                         input logic [15:0] wdata);
        logic [15:0] ins;
        logic        s;
        ins = {rd, 2'b00, addr};
        spi_cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--) tick(ins[i], s);
        // hold the last address bit until the device has synced the rise
        wait_clk(3);
        drv_en <= !rd;
        for (int k = 0; k < n; k++) begin
            for (int i = 7; i >= 0; i--) begin
                tick(wdata[8*(n-1-k)+i], s);
                rd_byte[i] = s;
            end
            if (rd) -> rd_ev;
        end
        wait_clk(5);
        spi_sclk <= 1'b0;
        wait_clk(4);
        spi_cs_n <= 1'b1;
        drv_en   <= 1'b1;
        wait_clk(8);
    endtask
endmodule
